// ===== hdl/tfs_pkg.sv
/*
 * Package of the trigger/flash sequencer: configuration carrier, modes,
 * trigger conditions, port widths and timing constants.
 * Assumes a single 10 MHz system clock.
 */
package tfs_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 1;
    localparam int CYC_PER_US = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int US_PER_MS = 1000;

    localparam int NUM_LINES = 8;
    localparam int SEL_W = 3;
    localparam int TIME_W = 16;
    localparam int MS_W = 16;

    localparam logic [NUM_LINES-1:0] DIR_RESET = 8'h00;

    typedef enum logic [1:0] {
        TFS_COND_LOW = 2'h0,
        TFS_COND_HIGH = 2'h1,
        TFS_COND_RISE = 2'h2,
        TFS_COND_FALL = 2'h3
    } tfs_cond_t;

    typedef enum logic [1:0] {
        TFS_SRC_DIGITAL = 2'h0,
        TFS_SRC_CAMERA = 2'h1,
        TFS_SRC_FIELDBUS = 2'h2
    } tfs_src_t;

    typedef struct packed {
        tfs_src_t src;
        tfs_cond_t cond;
        logic [SEL_W-1:0] trig_sel;
        logic [SEL_W-1:0] flash_sel;
        logic [SEL_W-1:0] grab_sel;
        logic [MS_W-1:0] timeout_ms;
        logic [TIME_W-1:0] trig_delay_us;
        logic [TIME_W-1:0] grab_delay_us;
        logic [TIME_W-1:0] flash_delay_us;
        logic [TIME_W-1:0] flash_dur_us;
    } tfs_cfg_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic aborted;
    } tfs_status_t;

endpackage

// ===== hdl/tfs_sequencer.sv
/*
 * Trigger/flash sequencer: waits for a trigger on a selected line, with
 * optional millisecond timeout, then times grab start and a flash pulse.
 * Assumes configuration is held stable while busy and the fieldbus
 * trigger is a one-cycle pulse from logic on the same clock.
 */
// Operation
// - After start, wait trigger, time timeout in ms
// - Timeout value zero waits forever
// - Trigger input line chosen by configuration
// - Low, high, rising or falling trigger condition
// - Programmable us delay before first flash
// - Flash active for programmed us duration
// - Camera mode: fast trigger input flashes fast output, no grab pulse
// - Camera mode ignores both grab and flash delays
// - Fieldbus trigger needs no extra trigger line
// - Eight lines each configurable input or output
// - Grab-to-flash us delay, digital lines only
// - Trigger-to-grab us delay, digital lines and fieldbus; grab delay digital only
`timescale 1ns/1ps

module tfs_sequencer #(
    parameter int NUM_LINES = tfs_pkg::NUM_LINES
) (
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    input wire logic i_start,
    input wire tfs_pkg::tfs_cfg_t i_cfg,
    input wire logic [NUM_LINES-1:0] i_line_dir,
    input wire logic [NUM_LINES-1:0] i_line_in,
    input wire logic [NUM_LINES-1:0] i_line_out_val,
    input wire logic i_fieldbus_trig,
    input wire logic i_cam_trig_in,
    output logic [NUM_LINES-1:0] o_line_out,
    output logic [NUM_LINES-1:0] o_line_oe,
    output logic o_cam_trig_out,
    output logic o_grab_start,
    output tfs_pkg::tfs_status_t o_status
);

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_WAIT = 7'h02,
        ST_TDLY = 7'h04,
        ST_GDLY = 7'h08,
        ST_FDLY = 7'h10,
        ST_FLASH = 7'h20,
        ST_CAM = 7'h40
    } tfs_state_t;

    localparam int TW = tfs_pkg::TIME_W;
    localparam int MW = tfs_pkg::MS_W;
    localparam int PW = $clog2(tfs_pkg::CYC_PER_US + 1);
    localparam int KW = $clog2(tfs_pkg::US_PER_MS + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(tfs_pkg::CYC_PER_US - 1);
    localparam logic [KW-1:0] KILO_LAST = KW'(tfs_pkg::US_PER_MS - 1);

    // Pick one bit out of the line vector
    function automatic logic pick(input logic [NUM_LINES-1:0] v,
                                  input logic [tfs_pkg::SEL_W-1:0] s);
        pick = v[s];
    endfunction

    // Three-stage synchronisers for pins
    logic [NUM_LINES-1:0] s1_ff, s2_ff, s3_ff;
    logic cs1_ff, cs2_ff, cs3_ff;
    logic [NUM_LINES-1:0] nxt_s1, nxt_s2, nxt_s3;
    logic nxt_cs1, nxt_cs2, nxt_cs3;
    logic [NUM_LINES-1:0] lines_ff, nxt_lines;
    logic cam_ff, nxt_cam;

    always_comb begin
        nxt_s1 = i_line_in;
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
        nxt_cs1 = i_cam_trig_in;
        nxt_cs2 = cs1_ff;
        nxt_cs3 = cs2_ff;
        nxt_lines = lines_ff;
        nxt_cam = cam_ff;
        for (int k = 0; k < NUM_LINES; k++) begin
            if (s2_ff[k] == s3_ff[k]) begin
                nxt_lines[k] = s3_ff[k];
            end
        end
        if (cs2_ff == cs3_ff) begin
            nxt_cam = cs3_ff;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            cs1_ff <= 1'b0;
            cs2_ff <= 1'b0;
            cs3_ff <= 1'b0;
            lines_ff <= '0;
            cam_ff <= 1'b0;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
            cs1_ff <= nxt_cs1;
            cs2_ff <= nxt_cs2;
            cs3_ff <= nxt_cs3;
            lines_ff <= nxt_lines;
            cam_ff <= nxt_cam;
        end
    end

    // Microsecond tick and millisecond tick
    logic [PW-1:0] pre_ff, nxt_pre;
    logic [KW-1:0] kilo_ff, nxt_kilo;
    logic us_tick, ms_tick;

    always_comb begin
        us_tick = (pre_ff == PRE_LAST);
        ms_tick = us_tick && (kilo_ff == KILO_LAST);
        nxt_pre = us_tick ? '0 : pre_ff + PW'(1);
        nxt_kilo = kilo_ff;
        if (us_tick) begin
            nxt_kilo = (kilo_ff == KILO_LAST) ? '0 : kilo_ff + KW'(1);
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pre_ff <= '0;
            kilo_ff <= '0;
        end else begin
            pre_ff <= nxt_pre;
            kilo_ff <= nxt_kilo;
        end
    end

    // Trigger detection
    logic trig_lvl, trig_prev_ff, nxt_trig_prev, trig_hit;

    always_comb begin
        trig_lvl = pick(lines_ff, i_cfg.trig_sel);
        nxt_trig_prev = trig_lvl;
        case (i_cfg.cond)
            tfs_pkg::TFS_COND_LOW: trig_hit = !trig_lvl;
            tfs_pkg::TFS_COND_HIGH: trig_hit = trig_lvl;
            tfs_pkg::TFS_COND_RISE: trig_hit = trig_lvl && !trig_prev_ff;
            tfs_pkg::TFS_COND_FALL: trig_hit = !trig_lvl && trig_prev_ff;
            default: trig_hit = 1'b0;
        endcase
        if (i_cfg.src == tfs_pkg::TFS_SRC_FIELDBUS) begin
            trig_hit = i_fieldbus_trig;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= nxt_trig_prev;
        end
    end

    // Sequencer
    tfs_state_t state_ff, nxt_state;
    logic [TW-1:0] cnt_ff, nxt_cnt;
    logic [MW-1:0] ms_ff, nxt_ms;
    logic flash_ff, nxt_flash;
    logic grab_ff, nxt_grab;
    logic done_ff, nxt_done;
    logic abort_ff, nxt_abort;
    logic cnt_end;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_ms = ms_ff;
        nxt_flash = 1'b0;
        nxt_grab = 1'b0;
        nxt_done = done_ff;
        nxt_abort = abort_ff;
        cnt_end = (cnt_ff == '0);
        if (us_tick && !cnt_end) begin
            nxt_cnt = cnt_ff - TW'(1);
        end
        case (state_ff)
            ST_IDLE: begin
                if (i_start) begin
                    nxt_state = ST_WAIT;
                    nxt_ms = '0;
                    nxt_done = 1'b0;
                    nxt_abort = 1'b0;
                end
            end
            ST_WAIT: begin
                if (ms_tick) begin
                    nxt_ms = ms_ff + MW'(1);
                end
                if (i_cfg.src == tfs_pkg::TFS_SRC_CAMERA) begin
                    nxt_state = ST_CAM;
                end else if (trig_hit) begin
                    nxt_state = ST_TDLY;
                    nxt_cnt = i_cfg.trig_delay_us;
                end else if (i_cfg.timeout_ms != '0 && ms_tick &&
                             ms_ff + MW'(1) >= i_cfg.timeout_ms) begin
                    nxt_state = ST_IDLE;
                    nxt_abort = 1'b1;
                end
            end
            ST_TDLY: begin
                if (cnt_end) begin
                    nxt_state = ST_GDLY;
                    nxt_cnt = (i_cfg.src == tfs_pkg::TFS_SRC_DIGITAL) ?
                              i_cfg.grab_delay_us : '0;
                end
            end
            ST_GDLY: begin
                if (cnt_end) begin
                    nxt_grab = 1'b1;
                    nxt_state = ST_FDLY;
                    nxt_cnt = (i_cfg.src == tfs_pkg::TFS_SRC_DIGITAL) ?
                              i_cfg.flash_delay_us : '0;
                end
            end
            ST_FDLY: begin
                if (cnt_end) begin
                    nxt_state = ST_FLASH;
                    nxt_flash = 1'b1;
                    nxt_cnt = i_cfg.flash_dur_us;
                end
            end
            ST_FLASH: begin
                // Hold until the tick after zero so the pulse is never short
                nxt_flash = !(cnt_end && us_tick);
                if (cnt_end && us_tick) begin
                    nxt_state = ST_IDLE;
                    nxt_done = 1'b1;
                end
            end
            ST_CAM: begin
                // Camera takes the fast trigger; no delays apply
                if (cam_ff) begin
                    nxt_flash = 1'b1;
                    nxt_state = ST_FLASH;
                    nxt_cnt = i_cfg.flash_dur_us;
                end else if (i_cfg.timeout_ms != '0 && ms_tick &&
                             ms_ff + MW'(1) >= i_cfg.timeout_ms) begin
                    nxt_state = ST_IDLE;
                    nxt_abort = 1'b1;
                end
                if (ms_tick) begin
                    nxt_ms = ms_ff + MW'(1);
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            ms_ff <= '0;
            flash_ff <= 1'b0;
            grab_ff <= 1'b0;
            done_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ms_ff <= nxt_ms;
            flash_ff <= nxt_flash;
            grab_ff <= nxt_grab;
            done_ff <= nxt_done;
            abort_ff <= nxt_abort;
        end
    end

    // Output lines: flash and grab on selected digital lines
    logic [NUM_LINES-1:0] out_ff, nxt_out;
    logic cam_out_ff, nxt_cam_out;

    always_comb begin
        nxt_out = i_line_out_val;
        nxt_cam_out = 1'b0;
        if (i_cfg.src == tfs_pkg::TFS_SRC_CAMERA) begin
            nxt_cam_out = nxt_flash;
        end else begin
            if (nxt_flash) begin
                nxt_out[i_cfg.flash_sel] = 1'b1;
            end
            if (i_cfg.src == tfs_pkg::TFS_SRC_DIGITAL && nxt_grab) begin
                nxt_out[i_cfg.grab_sel] = 1'b1;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            out_ff <= '0;
            cam_out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            cam_out_ff <= nxt_cam_out;
        end
    end

    assign o_line_out = out_ff & i_line_dir;
    assign o_line_oe = i_line_dir;
    assign o_cam_trig_out = cam_out_ff;
    assign o_grab_start = grab_ff;
    assign o_status = '{busy: (state_ff != ST_IDLE), done: done_ff, aborted: abort_ff};

endmodule

// ===== testbench/tfs_sequencer_monitor.sv
/*
 * Port checker for the trigger/flash sequencer.
 * Assumes one clock domain and the async active-low reset of the top.
 */
`timescale 1ns/1ps

module tfs_sequencer_monitor #(
    parameter int NUM_LINES = 8
) (
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    input wire logic i_start,
    input wire tfs_pkg::tfs_cfg_t i_cfg,
    input wire logic [NUM_LINES-1:0] i_line_dir,
    input wire logic [NUM_LINES-1:0] o_line_out,
    input wire logic [NUM_LINES-1:0] o_line_oe,
    input wire logic o_cam_trig_out,
    input wire logic o_grab_start,
    input wire tfs_pkg::tfs_status_t o_status
);
    logic [19:0] run_ff;
    logic [19:0] nxt_run;

    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RSTN);

    // Length of the current camera flash pulse
    always_comb begin
        nxt_run = o_cam_trig_out ? run_ff + 20'h1 : 20'h0;
    end
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            run_ff <= 20'h0;
        end else begin
            run_ff <= nxt_run;
        end
    end

    sequence s_take;
        i_start && !o_status.busy;
    endsequence
    sequence s_run;
        o_status.busy && !o_status.done && !o_status.aborted;
    endsequence

    a_start_taken: assert property (s_take |=> s_run)
        else $error("start not taken");
    a_oe_dir: assert property (o_line_oe == i_line_dir)
        else $error("enable differs from direction");
    a_out_dir: assert property ((o_line_out & ~i_line_dir) == '0)
        else $error("input line driven");
    a_grab_pulse: assert property (o_grab_start |=> !o_grab_start)
        else $error("grab pulse too long");
    a_grab_digital: assert property (o_grab_start |->
        o_status.busy && i_cfg.src != tfs_pkg::TFS_SRC_CAMERA)
        else $error("grab outside line or fieldbus run");
    a_cam_only: assert property (o_cam_trig_out |->
        i_cfg.src == tfs_pkg::TFS_SRC_CAMERA)
        else $error("camera flash in wrong mode");
    a_abort_quiet: assert property (o_status.aborted |->
        !o_grab_start && !o_cam_trig_out && !o_status.done)
        else $error("activity after abort");
    a_end_status: assert property ($fell(o_status.busy) |->
        o_status.done != o_status.aborted)
        else $error("end without one status");
    a_flash_len: assert property (run_ff <= 20'(i_cfg.flash_dur_us) * 20'ha + 20'hc)
        else $error("flash pulse too long");
endmodule

bind tfs_sequencer tfs_sequencer_monitor #(.NUM_LINES(NUM_LINES)) i_tfs_sequencer_monitor (
    .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .i_start(i_start), .i_cfg(i_cfg),
    .i_line_dir(i_line_dir), .o_line_out(o_line_out), .o_line_oe(o_line_oe),
    .o_cam_trig_out(o_cam_trig_out), .o_grab_start(o_grab_start), .o_status(o_status));

// ===== testbench/tfs_barrier.sv
/*
 * Far side: light barrier and camera trigger source, plus a lamp that
 * measures each flash pulse. Assumes unselected lines are pulled down.
 */
`timescale 1ns/1ps

module tfs_barrier (
    input wire logic clk,
    input wire logic [2:0] sel,
    input wire logic beam,
    input wire logic cam_req,
    input wire logic flash,
    output logic [7:0] lines,
    output logic cam,
    output int width,
    output int pulses
);
    int run = 0;

    initial begin
        width = 0;
        pulses = 0;
    end
    always @(negedge clk) begin
        lines <= 8'(beam) << sel;
        cam <= cam_req;
    end
    always @(posedge clk) begin
        if (flash === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            width <= run;
            pulses <= pulses + 1;
            run <= 0;
        end
    end
endmodule

// ===== testbench/test_trigger_flash_sequencer.sv
/*
 * Self-checking bench of the trigger/flash sequencer.
 * Assumes the barrier model and the bound port checker.
 */
`timescale 1ns/1ps

module test_trigger_flash_sequencer;
    logic I_REF_CLK, I_RSTN, i_start, i_fieldbus_trig, i_cam_trig_in, o_cam_trig_out;
    logic o_grab_start, beam, cam;
    tfs_pkg::tfs_cfg_t i_cfg;
    tfs_pkg::tfs_status_t o_status;
    logic [7:0] i_line_dir, i_line_in, i_line_out_val, o_line_out, o_line_oe;
    int miscompares = 0, cmp_count = 0, grabs = 0, width, pulses, g, p;
    int lgrabs = 0, lg;

    tfs_sequencer i_tfs_sequencer (.I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN),
        .i_start(i_start), .i_cfg(i_cfg), .i_line_dir(i_line_dir),
        .i_line_in(i_line_in), .i_line_out_val(i_line_out_val),
        .i_fieldbus_trig(i_fieldbus_trig), .i_cam_trig_in(i_cam_trig_in),
        .o_line_out(o_line_out), .o_line_oe(o_line_oe),
        .o_cam_trig_out(o_cam_trig_out), .o_grab_start(o_grab_start), .o_status(o_status));
    tfs_barrier i_tfs_barrier (.clk(I_REF_CLK), .sel(i_cfg.trig_sel), .beam(beam),
        .cam_req(cam), .flash(o_line_out[i_cfg.flash_sel] | o_cam_trig_out),
        .lines(i_line_in), .cam(i_cam_trig_in), .width(width), .pulses(pulses));

    initial begin
        I_REF_CLK = 1'b0;
        forever #50 I_REF_CLK = ~I_REF_CLK;
    end
    always @(posedge I_REF_CLK) begin
        if (o_grab_start === 1'b1) grabs <= grabs + 1;
        // Grab pulses seen on the selected digital output line
        if (o_line_out[i_cfg.grab_sel] === 1'b1) begin
            lgrabs <= lgrabs + 1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        cmp_count++;
        if (!(got >= lo && got <= hi)) begin
            miscompares++;
            $display("Error t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic go(input tfs_pkg::tfs_src_t s, input tfs_pkg::tfs_cond_t c,
                      input logic [15:0] t);
        g = grabs;
        lg = lgrabs;
        p = pulses;
        i_cfg.src = s;
        i_cfg.cond = c;
        i_cfg.timeout_ms = t;
        i_start = 1'b1;
        @(negedge I_REF_CLK);
        i_start = 1'b0;
    endtask
    task automatic idle(input int n);
        for (int k = 0; k < n && o_status.busy !== 1'b0; k++) @(negedge I_REF_CLK);
        repeat (2) @(negedge I_REF_CLK);
    endtask

    task automatic t_conds();
        logic pre;
        chk(o_line_oe, 32'h62);
        chk(o_line_out, 32'h40);
        for (int c = 0; c < 4; c++) begin
            pre = (c == 0 || c == 3);
            beam = pre;
            repeat (8) @(negedge I_REF_CLK);
            go(tfs_pkg::TFS_SRC_DIGITAL, tfs_pkg::tfs_cond_t'(c), 16'h0);
            repeat (60) @(negedge I_REF_CLK);
            chk(o_status.busy, 1);
            beam = !pre;
            repeat (50) @(negedge I_REF_CLK);
            chk(pulses, p);
            idle(500);
            chk(o_status.done, 1);
            chk(grabs, g + 1);
            chk(lgrabs, lg + 1);
            chk_in(width, 30, 42);
            chk(pulses, p + 1);
        end
    endtask
    task automatic t_timeout();
        beam = 1'b0;
        go(tfs_pkg::TFS_SRC_DIGITAL, tfs_pkg::TFS_COND_HIGH, 16'h2);
        repeat (9000) @(negedge I_REF_CLK);
        chk(o_status.busy, 1);
        idle(15000);
        chk(o_status.aborted, 1);
        chk(o_status.done, 0);
        chk(grabs, g);
        chk(pulses, p);
    endtask
    task automatic t_forever();
        go(tfs_pkg::TFS_SRC_DIGITAL, tfs_pkg::TFS_COND_HIGH, 16'h0);
        repeat (25000) @(negedge I_REF_CLK);
        chk(o_status.busy, 1);
        beam = 1'b1;
        idle(500);
        beam = 1'b0;
        chk(o_status.done, 1);
    endtask
    task automatic t_camera();
        i_cfg.trig_delay_us = 16'hc8;
        i_cfg.grab_delay_us = 16'hc8;
        i_cfg.flash_delay_us = 16'hc8;
        go(tfs_pkg::TFS_SRC_CAMERA, tfs_pkg::TFS_COND_HIGH, 16'h0);
        repeat (10) @(negedge I_REF_CLK);
        cam = 1'b1;
        idle(100);
        cam = 1'b0;
        chk(o_status.done, 1);
        chk(grabs, g);
        chk(lgrabs, lg);
        chk_in(width, 30, 42);
        chk(pulses, p + 1);
    endtask
    task automatic t_fieldbus();
        i_cfg.trig_delay_us = 16'h2;
        go(tfs_pkg::TFS_SRC_FIELDBUS, tfs_pkg::TFS_COND_HIGH, 16'h0);
        repeat (10) @(negedge I_REF_CLK);
        i_fieldbus_trig = 1'b1;
        @(negedge I_REF_CLK);
        i_fieldbus_trig = 1'b0;
        idle(300);
        chk(o_status.done, 1);
        chk(grabs, g + 1);
        chk(lgrabs, lg);
        chk(pulses, p + 1);
    endtask

    task automatic conclude();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge I_REF_CLK);
        miscompares++;
        conclude();
    end
    initial begin
        I_RSTN = 1'b0;
        i_start = 1'b0;
        i_fieldbus_trig = 1'b0;
        beam = 1'b0;
        cam = 1'b0;
        i_line_dir = 8'h62;
        i_line_out_val = 8'h40;
        i_cfg = '0;
        i_cfg.trig_sel = 3'h2;
        i_cfg.flash_sel = 3'h5;
        i_cfg.grab_sel = 3'h1;
        i_cfg.trig_delay_us = 16'h2;
        i_cfg.grab_delay_us = 16'h2;
        i_cfg.flash_delay_us = 16'h2;
        i_cfg.flash_dur_us = 16'h3;
        repeat (5) @(negedge I_REF_CLK);
        I_RSTN = 1'b1;
        @(negedge I_REF_CLK);
        t_conds();
        t_timeout();
        t_forever();
        t_camera();
        t_fieldbus();
        conclude();
    end
endmodule
